// ### asbl_ctrl.sv
// Host controller for an asynchronous 16-bit memory with two byte lanes
// Assumes a 10 MHz clock, one request at a time, memory pins direct
// Operation
// [R01] Chip select off or both lanes off means memory floats bus, standby
// [R02] Selected read, both lanes on, drives the whole word
// [R03] Read with only lower lane on drives low byte only
// [R04] Read with only upper lane on drives high byte only
// [R05] Selected write, both lanes on, stores all sixteen bits
// [R06] Write with only lower lane on stores low byte only
// [R07] Write with only upper lane on stores high byte only
// [R08] Write starts only when strobe, both selects and a lane are active
// [R09] Dropping any of those controls ends the internal write
// [R10] Host keeps write data stable around the terminating edge
// [R11] Output control high keeps memory off the bus
// [R12] Selects dropping together with strobe high cause no drive
// [R13] Host never drives the bus while memory drives it
// [R14] Strobe pulse at least setup time plus strobe-to-float delay
`timescale 1ns/100ps
module asbl_ctrl (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // User request
    input wire logic req_i,
    input wire logic req_write_i,
    input wire logic [asbl_pkg::ADDR_W-1:0] req_addr_i,
    input wire logic [1:0] req_lanes_i,
    input wire logic [asbl_pkg::DATA_W-1:0] req_wdata_i,
    // User answer
    output logic busy_o,
    output logic done_o,
    output logic [asbl_pkg::DATA_W-1:0] rdata_o,
    // Memory pins
    output logic [asbl_pkg::ADDR_W-1:0] addr_o,
    output logic chip_select_n_o,
    output logic chip_select_hi_o,
    output logic write_strobe_n_o,
    output logic output_drive_n_o,
    output logic upper_lane_n_o,
    output logic lower_lane_n_o,
    input wire logic [asbl_pkg::DATA_W-1:0] data_i,
    output logic [asbl_pkg::DATA_W-1:0] data_o,
    output logic [asbl_pkg::DATA_W-1:0] data_oe_o
);
    import asbl_pkg::*;

    asbl_state_t state;
    asbl_state_t next_state;
    logic [3:0] count;
    logic [3:0] next_count;
    logic is_write;
    logic next_is_write;
    logic [1:0] lanes;
    logic [1:0] next_lanes;
    logic [DATA_W-1:0] data_sync;
    logic [DATA_W-1:0] lane_mask;
    logic next_busy;
    logic next_done;
    logic [DATA_W-1:0] next_rdata;
    logic [ADDR_W-1:0] next_addr;
    logic next_cs_n;
    logic next_cs_hi;
    logic next_we_n;
    logic next_oe_n;
    logic next_ub_n;
    logic next_lb_n;
    logic [DATA_W-1:0] next_data;
    logic [DATA_W-1:0] next_data_oe;

    // Read data from the pins, synchronised
    asbl_sync #(.WIDTH(DATA_W)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(data_i),
        .q_o(data_sync)
    );

    // Bit mask of the lanes in use, bit 1 upper, bit 0 lower
    assign lane_mask = {{LANE_W{lanes[1]}}, {LANE_W{lanes[0]}}};

    // Sequencer next values
    always_comb
    begin
        next_state = state;
        next_count = count;
        next_is_write = is_write;
        next_lanes = lanes;
        next_busy = busy_o;
        next_done = 1'b0;
        next_rdata = rdata_o;
        next_addr = addr_o;
        next_cs_n = chip_select_n_o;
        next_cs_hi = chip_select_hi_o;
        next_we_n = write_strobe_n_o;
        next_oe_n = output_drive_n_o;
        next_ub_n = upper_lane_n_o;
        next_lb_n = lower_lane_n_o;
        next_data = data_o;
        next_data_oe = data_oe_o;
        case (state)
            ASBL_IDLE:
            begin
                // Deselected, bus floats on both sides
                next_cs_n = 1'b1; // R01
                next_cs_hi = 1'b0;
                next_ub_n = 1'b1;
                next_lb_n = 1'b1;
                next_we_n = 1'b1;
                next_oe_n = 1'b1;
                next_data_oe = '0;
                if (req_i && req_lanes_i != 2'b00)
                begin
                    next_busy = 1'b1;
                    next_is_write = req_write_i;
                    next_lanes = req_lanes_i;
                    next_addr = req_addr_i;
                    next_cs_n = 1'b0;
                    next_cs_hi = 1'b1;
                    next_ub_n = ~req_lanes_i[1]; // R03 R04 R06 R07
                    next_lb_n = ~req_lanes_i[0];
                    if (req_write_i)
                    begin
                        // Drive data only in used lanes, memory off bus
                        next_data = req_wdata_i;
                        next_data_oe = {{LANE_W{req_lanes_i[1]}},
                            {LANE_W{req_lanes_i[0]}}}; // R13
                        next_state = ASBL_WSETUP;
                    end
                    else
                    begin
                        next_oe_n = 1'b0; // R02 R11
                        next_count = READ_CYC;
                        next_state = ASBL_READ;
                    end
                end
            end
            ASBL_READ:
            begin
                next_count = count - 4'h1;
                if (count == 4'h1)
                begin
                    next_rdata = data_sync & lane_mask; // R03 R04
                    next_oe_n = 1'b1; // R11
                    next_cs_n = 1'b1;
                    next_cs_hi = 1'b0; // R12
                    next_ub_n = 1'b1;
                    next_lb_n = 1'b1;
                    next_count = RECOVER_CYC;
                    next_state = ASBL_RECOVER;
                end
            end
            ASBL_WSETUP:
            begin
                // All controls active together opens the write
                next_we_n = 1'b0; // R08
                next_count = WRITE_CYC;
                next_state = ASBL_WRITE;
            end
            ASBL_WRITE:
            begin
                next_count = count - 4'h1;
                if (count == 4'h1)
                begin
                    // Strobe rises first and ends the write
                    next_we_n = 1'b1; // R09 R14
                    next_state = ASBL_WEND;
                end
            end
            ASBL_WEND:
            begin
                // Data held a cycle past the terminating edge
                next_cs_n = 1'b1; // R10
                next_cs_hi = 1'b0;
                next_ub_n = 1'b1;
                next_lb_n = 1'b1;
                next_data_oe = '0;
                next_count = RECOVER_CYC;
                next_state = ASBL_RECOVER;
            end
            ASBL_RECOVER:
            begin
                next_count = count - 4'h1;
                if (count <= 4'h1)
                begin
                    next_busy = 1'b0;
                    next_done = 1'b1;
                    next_state = ASBL_IDLE;
                end
            end
            default:
            begin
                next_state = ASBL_IDLE;
                next_busy = 1'b0;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state <= ASBL_IDLE;
            count <= 4'h0;
            is_write <= 1'b0;
            lanes <= 2'b00;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            rdata_o <= '0;
            addr_o <= '0;
            chip_select_n_o <= 1'b1;
            chip_select_hi_o <= 1'b0;
            write_strobe_n_o <= 1'b1;
            output_drive_n_o <= 1'b1;
            upper_lane_n_o <= 1'b1;
            lower_lane_n_o <= 1'b1;
            data_o <= '0;
            data_oe_o <= '0;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
            is_write <= next_is_write;
            lanes <= next_lanes;
            busy_o <= next_busy;
            done_o <= next_done;
            rdata_o <= next_rdata;
            addr_o <= next_addr;
            chip_select_n_o <= next_cs_n;
            chip_select_hi_o <= next_cs_hi;
            write_strobe_n_o <= next_we_n;
            output_drive_n_o <= next_oe_n;
            upper_lane_n_o <= next_ub_n;
            lower_lane_n_o <= next_lb_n;
            data_o <= next_data;
            data_oe_o <= next_data_oe;
        end
    end
endmodule : asbl_ctrl

// ### asbl_pkg.sv
// Package: constants and types of the byte-lane static memory controller
// Assumes a 10 MHz clock and an asynchronous 16-bit memory on the pins
package asbl_pkg;
    // Data and address widths
    localparam int DATA_W = 16;
    localparam int ADDR_W = 21;
    localparam int LANE_W = 8;
    // Clock period in ns
    localparam int CLK_NS = 100;
    // Memory timing in ns
    localparam int READ_CYCLE_NS = 70;
    localparam int WRITE_PULSE_NS = 60;
    localparam int DATA_SETUP_TIME_NS = 30;
    localparam int STROBE_TO_FLOAT_DELAY_NS = 25;
    localparam int RECOVERY_NS = 25;
    // Cycle counts, least times rounded up
    // Read also waits two cycles for the two-stage data synchroniser
    localparam logic [3:0] READ_CYC = 4'((READ_CYCLE_NS + CLK_NS - 1) / CLK_NS + 2);
    localparam logic [3:0] WRITE_CYC = 4'((((WRITE_PULSE_NS > DATA_SETUP_TIME_NS
        + STROBE_TO_FLOAT_DELAY_NS) ? WRITE_PULSE_NS : DATA_SETUP_TIME_NS
        + STROBE_TO_FLOAT_DELAY_NS) + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] RECOVER_CYC = 4'((RECOVERY_NS + CLK_NS - 1) / CLK_NS);
    // Controller states
    typedef enum logic [2:0] {
        ASBL_IDLE = 3'b000,
        ASBL_READ = 3'b001,
        ASBL_WSETUP = 3'b010,
        ASBL_WRITE = 3'b011,
        ASBL_WEND = 3'b100,
        ASBL_RECOVER = 3'b101
    } asbl_state_t;
endpackage : asbl_pkg

// ### asbl_sync.sv
// Two-stage synchroniser for the data pins read back from the memory
// Assumes the pins are asynchronous to clk_i
`timescale 1ns/100ps
module asbl_sync #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Async in, synchronised out
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_q;

    // Next values
    always_comb
    begin
        next_meta = d_i;
        next_q = meta;
    end

    // Two flip-flops, first read only by the second
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta <= '0;
            q_o <= '0;
        end
        else
        begin
            meta <= next_meta;
            q_o <= next_q;
        end
    end
endmodule : asbl_sync

// ### asbl_chk_asserts.sv
// Checker: pin protocol of the byte-lane memory controller
// Assumes it is bound into asbl_ctrl and sees only its ports
`timescale 1ns/100ps
module asbl_chk (
    // Clock, reset and user side
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic req_write_i,
    input wire logic [1:0] req_lanes_i,
    input wire logic busy_o,
    input wire logic done_o,
    // Memory pins
    input wire logic chip_select_n_o,
    input wire logic chip_select_hi_o,
    input wire logic write_strobe_n_o,
    input wire logic output_drive_n_o,
    input wire logic upper_lane_n_o,
    input wire logic lower_lane_n_o,
    input wire logic [asbl_pkg::DATA_W-1:0] data_o,
    input wire logic [asbl_pkg::DATA_W-1:0] data_oe_o
);
    import asbl_pkg::*;
    logic sel;
    logic take;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Memory selected; request the controller must take
    assign sel = !chip_select_n_o && chip_select_hi_o;
    assign take = req_i && !busy_o && !done_o && (req_lanes_i != 2'h0);
    // Lanes, read steps and write steps
    sequence lane_s;
        {upper_lane_n_o, lower_lane_n_o} == ~$past(req_lanes_i);
    endsequence
    sequence rd_s;
        sel && !output_drive_n_o && write_strobe_n_o ##3 !sel && output_drive_n_o ##1 done_o;
    endsequence
    sequence wr_s;
        sel && write_strobe_n_o ##1 !write_strobe_n_o ##1 sel && write_strobe_n_o ##1 !sel
            ##1 done_o;
    endsequence
    read_walk_a:
        assert property (take && !$past(done_o) && !req_write_i |=> lane_s ##0 rd_s)
            else $error("read pin steps wrong");
    write_walk_a:
        assert property (take && !$past(done_o) && req_write_i |=> lane_s ##0 wr_s)
            else $error("write pin steps wrong");
    strobe_select_a:
        assert property (!write_strobe_n_o |-> sel && !(upper_lane_n_o && lower_lane_n_o))
            else $error("strobe without select");
    drive_clash_a:
        assert property (data_oe_o != 16'h0000 |-> output_drive_n_o)
            else $error("bus driven by both");
    strobe_pulse_a:
        assert property ($fell(write_strobe_n_o) |=> write_strobe_n_o)
            else $error("strobe pulse length");
    data_hold_a:
        assert property ($fell(write_strobe_n_o) |-> ($stable(data_o) && $stable(data_oe_o))[*2])
            else $error("write data moved");
    oe_read_a:
        assert property (!output_drive_n_o |-> sel && write_strobe_n_o)
            else $error("output enable outside read");
    select_drop_a:
        assert property ($rose(chip_select_n_o) |-> $fell(chip_select_hi_o) && write_strobe_n_o)
            else $error("selects drop apart");
    deselect_float_a:
        assert property (!sel |-> data_oe_o == 16'h0000 && output_drive_n_o)
            else $error("drive while deselected");
endmodule : asbl_chk
bind asbl_ctrl asbl_chk i_asbl_chk (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i),
    .req_write_i(req_write_i), .req_lanes_i(req_lanes_i), .busy_o(busy_o), .done_o(done_o),
    .chip_select_n_o(chip_select_n_o), .chip_select_hi_o(chip_select_hi_o),
    .write_strobe_n_o(write_strobe_n_o), .output_drive_n_o(output_drive_n_o),
    .upper_lane_n_o(upper_lane_n_o), .lower_lane_n_o(lower_lane_n_o), .data_o(data_o),
    .data_oe_o(data_oe_o));

// ### asbl_mem_model.sv
// Behavioural 16-bit memory with two byte lanes, level controlled
// Assumes the bench resolves the shared data bus from both enables
`timescale 1ns/100ps
module asbl_mem_model (
    // Control pins
    input wire logic chip_select_n_i,
    input wire logic chip_select_hi_i,
    input wire logic write_strobe_n_i,
    input wire logic output_drive_n_i,
    input wire logic upper_lane_n_i,
    input wire logic lower_lane_n_i,
    input wire logic [3:0] addr_i,
    // Data pins
    input wire logic [15:0] dq_i,
    output logic [15:0] dq_o,
    output logic [15:0] dq_en_o
);
    logic [15:0] mem [16];
    logic sel;
    logic wr;
    logic [1:0] lanes;
    // Selected with a lane; otherwise standby
    assign sel = !chip_select_n_i && chip_select_hi_i && !(upper_lane_n_i && lower_lane_n_i);
    // Write lasts only while all controls overlap
    assign wr = sel && !write_strobe_n_i;
    // Read drives enabled lanes only
    assign dq_en_o = (sel && write_strobe_n_i && !output_drive_n_i) ?
        {{8{!upper_lane_n_i}}, {8{!lower_lane_n_i}}} : 16'h0000;
    assign dq_o = mem[addr_i];
    // Lanes of the write in progress
    always @(posedge wr) lanes = {!upper_lane_n_i, !lower_lane_n_i};
    // Store enabled bytes at the terminating edge
    always @(negedge wr)
    begin
        if (lanes[0]) mem[addr_i][7:0] = dq_i[7:0];
        if (lanes[1]) mem[addr_i][15:8] = dq_i[15:8];
    end
endmodule : asbl_mem_model

// ### tb.sv
// Bench: byte-lane memory controller against a behavioural memory
// Assumes asbl_pkg, asbl_ctrl and asbl_mem_model are compiled first
`timescale 1ns/100ps
module tb;
    import asbl_pkg::*;
    typedef struct packed {logic w; logic [3:0] a; logic [1:0] l; logic [15:0] d, e;} asbl_row_t;
    logic clk_i = 1'b0, rst_i = 1'b1, req_i = 1'b0, req_write_i = 1'b0;
    logic [1:0] req_lanes_i = 2'h0;
    logic [ADDR_W-1:0] req_addr_i = 21'h0, addr_o;
    logic [DATA_W-1:0] req_wdata_i = 16'h0000, flt = 16'ha5a5;
    logic [DATA_W-1:0] data_i, data_o, data_oe_o, rdata_o, mq, men;
    logic busy_o, done_o, cs_n, cs_hi, we_n, oe_n, up_n, lo_n;
    int checks = 0, n_mismatch = 0;
    asbl_row_t rows [8] = '{'{1'b1, 4'h1, 2'h3, 16'h1234, 16'h0}, '{1'b0, 4'h1, 2'h3, 16'h0, 16'h1234},
        '{1'b1, 4'h1, 2'h1, 16'hffab, 16'h0}, '{1'b0, 4'h1, 2'h3, 16'h0, 16'h12ab},
        '{1'b1, 4'h1, 2'h2, 16'hcdff, 16'h0}, '{1'b0, 4'h1, 2'h3, 16'h0, 16'hcdab},
        '{1'b0, 4'h1, 2'h1, 16'h0, 16'h00ab}, '{1'b0, 4'h1, 2'h2, 16'h0, 16'hcd00}};
    asbl_ctrl i_asbl_ctrl (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .req_write_i(req_write_i),
        .req_addr_i(req_addr_i), .req_lanes_i(req_lanes_i), .req_wdata_i(req_wdata_i),
        .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o), .addr_o(addr_o),
        .chip_select_n_o(cs_n), .chip_select_hi_o(cs_hi), .write_strobe_n_o(we_n),
        .output_drive_n_o(oe_n), .upper_lane_n_o(up_n), .lower_lane_n_o(lo_n),
        .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o));
    asbl_mem_model i_asbl_mem_model (.chip_select_n_i(cs_n), .chip_select_hi_i(cs_hi),
        .write_strobe_n_i(we_n), .output_drive_n_i(oe_n), .upper_lane_n_i(up_n),
        .lower_lane_n_i(lo_n), .addr_i(addr_o[3:0]), .dq_i(data_i), .dq_o(mq), .dq_en_o(men));
    // Clock; floating bits change every cycle
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) flt <= ~flt;
    assign data_i = (data_oe_o & data_o) | (~data_oe_o & men & mq) | (~data_oe_o & ~men & flt);
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    task automatic drive(input logic w, input logic [3:0] a, input logic [1:0] l, input logic [15:0] d);
        repeat (2) @(negedge clk_i);
        req_i = 1'b1;
        req_write_i = w;
        req_addr_i = {17'h0, a};
        req_lanes_i = l;
        req_wdata_i = d;
    endtask : drive
    task automatic wait_done();
        int n;
        n = 0;
        while (done_o !== 1'b1 && n < 20)
        begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 20)
        begin
            n_mismatch++;
            print_verdict();
        end
    endtask : wait_done
    task automatic access(input asbl_row_t r);
        drive(r.w, r.a, r.l, r.d);
        @(negedge clk_i);
        req_i = 1'b0;
        wait_done();
        if (!r.w) check("rdata", rdata_o, r.e);
    endtask : access
    task automatic reset_chk();
        check("pins", {10'h0, cs_n, cs_hi, we_n, oe_n, up_n, lo_n}, 16'h002f);
        check("rdata", rdata_o, 16'h0000);
        check("drive", data_oe_o, 16'h0000);
    endtask : reset_chk
    // Reset, table of accesses, then awkward cases
    initial
    begin
        repeat (4) @(negedge clk_i);
        rst_i = 1'b0;
        reset_chk();
        foreach (rows[i]) access(rows[i]);
        // No lane enabled: request refused
        drive(1'b1, 4'h1, 2'h0, 16'h0000);
        repeat (3) @(negedge clk_i);
        check("busy", {15'h0, busy_o}, 16'h0000);
        req_i = 1'b0;
        // New data while busy is ignored
        drive(1'b1, 4'h3, 2'h3, 16'h1111);
        @(negedge clk_i);
        req_wdata_i = 16'h2222;
        @(negedge clk_i);
        req_i = 1'b0;
        wait_done();
        access('{1'b0, 4'h3, 2'h3, 16'h0, 16'h1111});
        // Reset in mid read, then recover
        drive(1'b0, 4'h1, 2'h3, 16'h0000);
        @(negedge clk_i);
        req_i = 1'b0;
        rst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        rst_i = 1'b0;
        reset_chk();
        access('{1'b0, 4'h1, 2'h3, 16'h0, 16'hcdab});
        print_verdict();
    end
endmodule : tb
